// >>> hdl/ldm_decoder.sv
// Purpose: Message decoder and responder for one device on a serial loop
// Assumes: One frame in per inValid pulse, answer one cycle later
// Notes: Software feeds talker bytes one at a time through TXDATA
`timescale 1ns/10ps
module ldm_decoder import ldm_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Loop frames
  input wire logic inValid,
  input wire logic [10:0] inFrame,
  output logic outValid,
  output logic [10:0] outFrame,
  // Device side
  output logic talkActive,
  output logic listenActive,
  output logic remoteCtl,
  output logic devClear
);

  typedef struct packed {
    logic talker;
    logic listener;
    logic remote;
    logic remEn;
    logic asyncMode;
    logic parallel_poll_configure;
    logic ppSense;
    logic [2:0] ppBit;
    logic pendT;
    logic pendL;
    logic autoDone;
    logic secDone;
    logic [17:0] ctrl;
    logic [7:0] txByte;
    logic txPend;
    logic [7:0] accId;
    logic [31:0] idStr;
    ldm_talk_t tk;
    logic stopReq;
    logic [2:0] idIdx;
    logic [10:0] outFrame;
    logic outValid;
    logic devClr;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } ldm_state_t;

  ldm_state_t st_ff;
  ldm_state_t nxt_st;

  // Control field positions inside ctrl
  function automatic logic [4:0] ctlPrim(input logic [17:0] c);
    ctlPrim = c[4:0];
  endfunction : ctlPrim

  function automatic logic [4:0] ctlSec(input logic [17:0] c);
    ctlSec = c[9:5];
  endfunction : ctlSec

  function automatic logic isRdy(input logic [10:0] f, input logic [7:0] code);
    isRdy = (f[10:8] == CLS_RDY) && (f[7:0] == code);
  endfunction : isRdy

  function automatic logic [10:0] dataFrame(input logic [7:0] b, input logic srq);
    dataFrame = {CLS_DATA[2:1], srq, b};
  endfunction : dataFrame

  logic twoByte, aaCap, multiCap, rlCap, canSrc, accCap, idCap, srq;
  assign twoByte = st_ff.ctrl[10];
  assign aaCap = st_ff.ctrl[11];
  assign multiCap = st_ff.ctrl[12];
  assign rlCap = st_ff.ctrl[13];
  assign canSrc = st_ff.ctrl[14];
  assign accCap = st_ff.ctrl[15];
  assign idCap = st_ff.ctrl[16];
  assign srq = st_ff.ctrl[17];

  logic [2:0] cls;
  logic [7:0] lo;
  logic [4:0] adr;
  logic isCmd, accWr, accRd;
  assign cls = inFrame[10:8];
  assign lo = inFrame[7:0];
  assign adr = inFrame[4:0];
  assign isCmd = cls == CLS_CMD;
  assign accWr = psel && penable && st_ff.pready && pwrite;
  assign accRd = psel && penable && !st_ff.pready;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.outValid = 1'b0;
    nxt_st.devClr = 1'b0;
    // One wait state: pready rises in the second access cycle
    nxt_st.pready = accRd;
    nxt_st.pslverr = 1'b0;
    if (accRd) begin
      unique case (paddr)
        OFS_CTRL: nxt_st.prdata = {14'h0000, st_ff.ctrl};
        OFS_STATUS: nxt_st.prdata = {17'h0_0000, st_ff.secDone, st_ff.autoDone,
          st_ff.tk, st_ff.txPend, st_ff.asyncMode, st_ff.ppBit, st_ff.ppSense,
          st_ff.parallel_poll_configure, st_ff.remEn, st_ff.remote, st_ff.listener, st_ff.talker};
        OFS_TXDATA: nxt_st.prdata = {23'h00_0000, st_ff.txPend, st_ff.txByte};
        OFS_ACCID: nxt_st.prdata = {24'h00_0000, st_ff.accId};
        OFS_IDSTR: nxt_st.prdata = st_ff.idStr;
        default: begin
          nxt_st.prdata = 32'h0000_0000;
          nxt_st.pslverr = 1'b1;
        end
      endcase
    end
    if (accWr) begin
      unique case (paddr)
        OFS_CTRL: nxt_st.ctrl = pwdata[17:0];
        OFS_TXDATA: nxt_st.txByte = pwdata[7:0];
        OFS_ACCID: nxt_st.accId = pwdata[7:0];
        OFS_IDSTR: nxt_st.idStr = pwdata;
        default: ;
      endcase
    end
    if (inValid) begin
      nxt_st.outValid = 1'b1;
      nxt_st.outFrame = inFrame;
      // Pending primary match survives only the ready-for-command handshake
      if (!isRdy(inFrame, RDY_FOR_CMD)) begin
        nxt_st.pendT = 1'b0;
        nxt_st.pendL = 1'b0;
      end
      if (isCmd) begin
        if (lo[6:4] == GRP_UNIVERSAL) begin
          nxt_st.asyncMode = 1'b0;
        end
        if (lo == CMD_ASYNC_EN) begin
          nxt_st.asyncMode = 1'b1;
        end
        if (lo == CMD_NOT_REMOTE && rlCap) begin
          nxt_st.remote = 1'b0;
          nxt_st.remEn = 1'b0;
        end
        if (lo == CMD_REMOTE_EN && rlCap) begin
          nxt_st.remEn = 1'b1;
        end
        if (lo == CMD_PP_UNCONFIG) begin
          nxt_st.parallel_poll_configure = 1'b0;
        end
        if (st_ff.listener) begin
          if (lo == CMD_PP_DISABLE) begin
            nxt_st.parallel_poll_configure = 1'b0;
          end
          if (lo[7:4] == GRP_PP_CONFIG) begin
            nxt_st.parallel_poll_configure = 1'b1;
            nxt_st.ppSense = lo[3];
            nxt_st.ppBit = lo[2:0];
          end
          if (lo == CMD_SEL_CLEAR) begin
            nxt_st.devClr = 1'b1;
          end
        end
        unique case (lo[7:5])
          GRP_LISTEN: begin
            if (adr == ADDR_ILLEGAL) begin
              nxt_st.listener = 1'b0;
            end else if (adr == ctlPrim(st_ff.ctrl)) begin
              if (twoByte) begin
                nxt_st.pendL = 1'b1;
              end else begin
                nxt_st.listener = 1'b1;
                nxt_st.remote = st_ff.remote | st_ff.remEn;
              end
            end
          end
          GRP_TALK: begin
            if (adr == ctlPrim(st_ff.ctrl) && adr != ADDR_ILLEGAL) begin
              if (twoByte) begin
                nxt_st.pendT = 1'b1;
              end else begin
                nxt_st.talker = 1'b1;
              end
            end else begin
              nxt_st.talker = 1'b0;
              nxt_st.tk = TK_IDLE;
            end
          end
          GRP_SECOND: begin
            if (twoByte && adr != ADDR_ILLEGAL && adr == ctlSec(st_ff.ctrl)) begin
              if (st_ff.pendT) begin
                nxt_st.talker = 1'b1;
              end
              if (st_ff.pendL) begin
                nxt_st.listener = 1'b1;
                nxt_st.remote = st_ff.remote | st_ff.remEn;
              end
            end else if (twoByte) begin
              nxt_st.talker = 1'b0;
              nxt_st.tk = TK_IDLE;
            end
          end
          default: ;
        endcase
      end else if (cls == CLS_RDY) begin
        unique case (lo[7:5])
          GRP_AUTO: begin
            if (aaCap && !st_ff.autoDone && adr != ADDR_ILLEGAL) begin
              nxt_st.ctrl[4:0] = adr;
              nxt_st.autoDone = 1'b1;
              nxt_st.outFrame = {inFrame[10:5], 5'(adr + 5'h01)};
            end
          end
          GRP_EXT_SEC: begin
            if (multiCap && !st_ff.secDone && adr != ADDR_ILLEGAL) begin
              nxt_st.ctrl[9:5] = adr;
              nxt_st.secDone = 1'b1;
              nxt_st.outFrame = {inFrame[10:5], 5'(adr + 5'h01)};
            end
          end
          GRP_MULT_PRIM: begin
            if (multiCap && !st_ff.autoDone && adr != ADDR_ILLEGAL) begin
              nxt_st.ctrl[4:0] = adr;
              nxt_st.autoDone = 1'b1;
              nxt_st.outFrame = {inFrame[10:5], 5'(adr + 5'h01)};
            end
          end
          default: ;
        endcase
        if (st_ff.talker && st_ff.tk == TK_IDLE) begin
          if (lo == RDY_SEND_DATA && canSrc) begin
            nxt_st.stopReq = 1'b0;
            if (st_ff.txPend) begin
              // An unsent byte left by an interruption is sent first
              nxt_st.outFrame = dataFrame(st_ff.txByte, srq);
              nxt_st.txPend = 1'b0;
              nxt_st.tk = TK_DATA;
            end else begin
              nxt_st.outFrame = {CLS_RDY, RDY_END_OK};
            end
          end
          if (lo == RDY_SEND_ACC && accCap) begin
            nxt_st.outFrame = dataFrame(st_ff.accId, srq);
            nxt_st.tk = TK_ACC;
          end
          if (lo == RDY_SEND_ID && idCap) begin
            nxt_st.outFrame = dataFrame(st_ff.idStr[31:24], srq);
            nxt_st.idIdx = 3'h1;
            nxt_st.tk = TK_ID;
          end
        end
        if (lo == RDY_NOT_READY && st_ff.tk != TK_IDLE) begin
          nxt_st.stopReq = 1'b1;
        end
      end else if (!inFrame[10] && st_ff.tk != TK_IDLE) begin
        // Own frame has come round: source the next one in its place
        nxt_st.outFrame = {CLS_RDY, RDY_END_OK};
        nxt_st.tk = TK_IDLE;
        nxt_st.stopReq = 1'b0;
        if (st_ff.tk == TK_DATA && !st_ff.stopReq && st_ff.txPend) begin
          nxt_st.outFrame = dataFrame(st_ff.txByte, srq);
          nxt_st.txPend = 1'b0;
          nxt_st.tk = TK_DATA;
        end
        if (st_ff.tk == TK_ID && !st_ff.stopReq && st_ff.idIdx <= ID_LAST) begin
          unique case (st_ff.idIdx)
            3'h1: nxt_st.outFrame = dataFrame(st_ff.idStr[23:16], srq);
            3'h2: nxt_st.outFrame = dataFrame(st_ff.idStr[15:8], srq);
            3'h3: nxt_st.outFrame = dataFrame(st_ff.idStr[7:0], srq);
            3'h4: nxt_st.outFrame = dataFrame(CHAR_CR, srq);
            default: nxt_st.outFrame = dataFrame(CHAR_LF, srq);
          endcase
          nxt_st.idIdx = 3'(st_ff.idIdx + 3'h1);
          nxt_st.tk = TK_ID;
        end
      end else if (inFrame[10:9] == 2'b11 && st_ff.parallel_poll_configure && srq == st_ff.ppSense) begin
        nxt_st.outFrame[st_ff.ppBit] = 1'b1;
      end
    end
    // A new byte from software wins over consumption in the same cycle
    if (accWr && paddr == OFS_TXDATA) begin
      nxt_st.txPend = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
      st_ff.ctrl <= RST_CTRL;
      st_ff.accId <= RST_ACCID;
      st_ff.idStr <= RST_IDSTR;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign prdata = st_ff.prdata;
  assign pready = st_ff.pready;
  assign pslverr = st_ff.pslverr;
  assign outValid = st_ff.outValid;
  assign outFrame = st_ff.outFrame;
  assign talkActive = st_ff.talker;
  assign listenActive = st_ff.listener;
  assign remoteCtl = st_ff.remote;
  assign devClear = st_ff.devClr;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence ownTalk;
    inValid && isCmd && lo[7:5] == GRP_TALK && adr == ctlPrim(st_ff.ctrl) && adr != ADDR_ILLEGAL;
  endsequence
  sequence ownSec;
    inValid && isCmd && lo[7:5] == GRP_SECOND && adr == ctlSec(st_ff.ctrl) && adr != ADDR_ILLEGAL;
  endsequence

  sequence heldReturn;
    inValid && !inFrame[10] && st_ff.tk != TK_IDLE && st_ff.stopReq;
  endsequence

  chk_talk_single: assert property (!twoByte ##0 ownTalk |=> talkActive)
    else $error("Own talk address did not make talker");
  chk_talk_pending: assert property (twoByte ##0 ownTalk |=> st_ff.pendT)
    else $error("Own talk address did not arm the secondary match");
  // The ready-for-command frame may sit between the two address bytes, so the pair is tracked by pendT
  chk_talk_second: assert property (twoByte && st_ff.pendT ##0 ownSec |=> talkActive)
    else $error("Secondary after own talk did not make talker");
  chk_talk_foreign: assert property (inValid && isCmd && lo[7:5] == GRP_TALK
      && adr != ctlPrim(st_ff.ctrl) |=> !talkActive)
    else $error("Foreign talk address left talker active");
  chk_sec_foreign: assert property (twoByte && inValid && isCmd && lo[7:5] == GRP_SECOND
      && adr != ctlSec(st_ff.ctrl) |=> !talkActive)
    else $error("Foreign secondary left talker active");
  chk_auto_incr: assert property (inValid && cls == CLS_RDY && lo[7:5] == GRP_AUTO
      && aaCap && !st_ff.autoDone && adr != ADDR_ILLEGAL
      |=> outValid && outFrame[4:0] == $past(adr) + 5'h01)
    else $error("Auto address not incremented");
  chk_async_clear: assert property (inValid && isCmd && lo[6:4] == GRP_UNIVERSAL
      && lo != CMD_ASYNC_EN |=> !st_ff.asyncMode)
    else $error("Universal command left async mode on");
  chk_pp_unconf: assert property (inValid && isCmd && lo == CMD_PP_UNCONFIG |=> !st_ff.parallel_poll_configure)
    else $error("Parallel poll still enabled");
  chk_nrd_flag: assert property (st_ff.tk != TK_IDLE && inValid
      && isRdy(inFrame, RDY_NOT_READY) |=> st_ff.stopReq)
    else $error("Not-ready frame did not stop the talker");
  chk_nrd_stop: assert property (heldReturn |=> outValid
      && outFrame == {CLS_RDY, RDY_END_OK} && talkActive)
    else $error("Interrupted talker did not end");
  chk_forward_once: assert property (inValid |=> outValid ##1 !outValid || $past(inValid))
    else $error("Frame not forwarded one cycle later");
  chk_clear_pulse: assert property (devClear |-> $past(st_ff.listener))
    else $error("Device clear without listener");

endmodule : ldm_decoder

// >>> hdl/ldm_pkg.sv
// Purpose: Constants for the loop device message decoder
// Assumes: 11-bit frames, class in bits 10:8, payload in bits 7:0
// Notes: Register offsets are byte addresses on a 32-bit APB
package ldm_pkg;
  // Frame classes
  localparam logic [2:0] CLS_CMD = 3'h4;
  localparam logic [2:0] CLS_RDY = 3'h5;
  localparam logic [2:0] CLS_DATA = 3'h0;
  // Command payloads
  localparam logic [7:0] CMD_ADDR_NOP = 8'h00;
  localparam logic [7:0] CMD_SEL_CLEAR = 8'h04;
  localparam logic [7:0] CMD_PP_DISABLE = 8'h05;
  localparam logic [7:0] CMD_PP_UNCONFIG = 8'h15;
  localparam logic [7:0] CMD_ASYNC_EN = 8'h18;
  localparam logic [7:0] CMD_REMOTE_EN = 8'h92;
  localparam logic [7:0] CMD_NOT_REMOTE = 8'h93;
  localparam logic [2:0] GRP_LISTEN = 3'h1;
  localparam logic [2:0] GRP_TALK = 3'h2;
  localparam logic [2:0] GRP_SECOND = 3'h3;
  localparam logic [3:0] GRP_PP_CONFIG = 4'h8;
  localparam logic [2:0] GRP_UNIVERSAL = 3'h1;
  localparam logic [4:0] ADDR_ILLEGAL = 5'h1f;
  // Ready payloads
  localparam logic [7:0] RDY_FOR_CMD = 8'h00;
  localparam logic [7:0] RDY_END_OK = 8'h40;
  localparam logic [7:0] RDY_NOT_READY = 8'h42;
  localparam logic [7:0] RDY_SEND_DATA = 8'h60;
  localparam logic [7:0] RDY_SEND_ID = 8'h62;
  localparam logic [7:0] RDY_SEND_ACC = 8'h63;
  localparam logic [2:0] GRP_AUTO = 3'h4;
  localparam logic [2:0] GRP_EXT_SEC = 3'h6;
  localparam logic [2:0] GRP_MULT_PRIM = 3'h7;
  // Line end characters of the ID string
  localparam logic [7:0] CHAR_CR = 8'h0d;
  localparam logic [7:0] CHAR_LF = 8'h0a;
  localparam logic [2:0] ID_LAST = 3'h5;
  // APB map
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_TXDATA = 8'h08;
  localparam logic [7:0] OFS_ACCID = 8'h0c;
  localparam logic [7:0] OFS_IDSTR = 8'h10;
  // Reset values
  localparam logic [17:0] RST_CTRL = 18'h0_7c00;
  localparam logic [7:0] RST_ACCID = 8'h00;
  localparam logic [31:0] RST_IDSTR = 32'h4c44_4d30;
  typedef enum logic [1:0] {
    TK_IDLE = 2'b00,
    TK_DATA = 2'b01,
    TK_ACC = 2'b10,
    TK_ID = 2'b11
  } ldm_talk_t;
endpackage : ldm_pkg

// >>> tb/ldm_loop_partner.sv
// Purpose: Behavioural loop controller feeding frames into the decoder
// Assumes: One frame request at a time, accepted at an edge with reqReady high
// Notes: Frame lines toggle between frames so a stale value is never reused
`timescale 1ns/10ps
module ldm_loop_partner import ldm_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Requests from the bench
  input wire logic reqValid,
  input wire logic [10:0] reqFrame,
  input wire logic slow,
  output logic reqReady,
  // Frames into the device
  output logic inValid,
  output logic [10:0] inFrame
);
  logic rfcPend;
  logic [1:0] gap;

  assign reqReady = (gap == 2'h0) && !rfcPend;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      inValid <= 1'b0;
      inFrame <= 11'h000;
      rfcPend <= 1'b0;
      gap <= 2'h0;
    end else begin
      inValid <= 1'b0;
      inFrame <= ~inFrame;
      if (gap != 2'h0) begin
        gap <= gap - 2'h1;
      end else if (rfcPend) begin
        inValid <= 1'b1;
        inFrame <= {CLS_RDY, RDY_FOR_CMD};
        rfcPend <= 1'b0;
        gap <= slow ? 2'h2 : 2'h0;
      end else if (reqValid) begin
        inValid <= 1'b1;
        inFrame <= reqFrame;
        // Every command is chased by a handshake frame
        rfcPend <= (reqFrame[10:8] == CLS_CMD);
        gap <= slow ? 2'h3 : 2'h0;
      end
    end
  end
endmodule : ldm_loop_partner

// >>> tb/ldm_decoder_tb_top.sv
// Purpose: Self-checking bench for the loop message decoder
// Assumes: One answer frame per input frame, compared in order from a queue
// Notes: Level outputs are checked only after the expected queue drains
`timescale 1ns/10ps
module ldm_decoder_tb_top import ldm_pkg::*;;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr, b;
  logic [31:0] pwdata, prdata, rd;
  logic inValid, outValid, talkActive, listenActive, remoteCtl, devClear;
  logic [10:0] inFrame, outFrame, reqFrame;
  logic reqValid, slow, reqReady;
  logic [11:0] expQ[$];
  logic [11:0] x;
  logic [7:0] idB[6];
  logic [10:0] aIn[5], aOut[5];
  int nMismatch, cmpCount, t;

  ldm_decoder i_ldm_decoder (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .inValid(inValid), .inFrame(inFrame), .outValid(outValid),
    .outFrame(outFrame), .talkActive(talkActive), .listenActive(listenActive),
    .remoteCtl(remoteCtl), .devClear(devClear));
  ldm_loop_partner i_ldm_loop_partner (.clk(clk), .rst_n(rst_n), .reqValid(reqValid),
    .reqFrame(reqFrame), .slow(slow), .reqReady(reqReady), .inValid(inValid),
    .inFrame(inFrame));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task fail(input string m);
    nMismatch++;
    $display("mismatch at %0t: %s", $time, m);
  endtask : fail
  task cmp1(input logic g, input logic e);
    cmpCount++;
    if (g !== e) fail("flag differs");
  endtask : cmp1
  task cmp11(input logic [10:0] g, input logic [10:0] e);
    cmpCount++;
    if (g !== e) fail($sformatf("frame %h, expected %h", g, e));
  endtask : cmp11
  task cmp32(input logic [31:0] g, input logic [31:0] e);
    cmpCount++;
    if (g !== e) fail($sformatf("read %h, expected %h", g, e));
  endtask : cmp32

  task wrapUp();
    $display("Mismatches %0d, comparisons %0d", nMismatch, cmpCount);
    if (nMismatch == 0 && cmpCount > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrapUp

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) fail("bus timeout");
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task regChk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input logic ee);
    apb(1'b0, a, 32'h0000_0000);
    cmp32(rd & m, e);
    cmp1(er, ee);
  endtask : regChk
  task regWr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    cmp1(er, 1'b0);
  endtask : regWr

  task send(input logic [10:0] f, input logic [10:0] e, input logic clr = 1'b0);
    int n;
    expQ.push_back({clr, e});
    if (f[10:8] == CLS_CMD) expQ.push_back({1'b0, CLS_RDY, RDY_FOR_CMD});
    @(posedge clk);
    reqValid <= 1'b1;
    reqFrame <= f;
    slow <= 1'($urandom_range(1, 0));
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (reqReady !== 1'b1 && n < 20);
    reqValid <= 1'b0;
  endtask : send
  task drain();
    int n;
    n = 0;
    while (expQ.size() != 0 && n < 60) begin
      @(posedge clk);
      n++;
    end
    if (expQ.size() != 0) fail("answer missing");
    #1;
  endtask : drain

  // Oldest note is matched against each answer frame
  always @(posedge clk) begin
    if (rst_n && outValid === 1'b1) begin
      if (expQ.size() == 0) begin
        fail("unexpected frame");
      end else begin
        x = expQ.pop_front();
        cmp11(outFrame, x[10:0]);
        cmp1(devClear, x[11]);
      end
    end
  end

  initial begin
    #200000;
    fail("watchdog expired");
    wrapUp();
  end

  initial begin
    {rst_n, psel, penable, pwrite, reqValid, slow} = '0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    reqFrame = 11'h000;
    t = $urandom(32'h0000_259b);
    aIn = '{11'h5fe, 11'h583, 11'h59f, 11'h5de, 11'h5c2};
    aOut = '{11'h5ff, 11'h583, 11'h59f, 11'h5df, 11'h5c2};
    idB = '{RST_IDSTR[31:24], RST_IDSTR[23:16], RST_IDSTR[15:8], RST_IDSTR[7:0], CHAR_CR, CHAR_LF};
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    regChk(OFS_CTRL, 32'hffff_ffff, {14'h0000, RST_CTRL}, 1'b0);
    regChk(OFS_ACCID, 32'hffff_ffff, {24'h00_0000, RST_ACCID}, 1'b0);
    regChk(OFS_IDSTR, 32'hffff_ffff, RST_IDSTR, 1'b0);
    regChk(8'h14, 32'hffff_ffff, 32'h0000_0000, 1'b1);
    // Multiple primary taken first, so a later auto address passes untouched
    foreach (aIn[i]) send(aIn[i], aOut[i]);
    drain();
    regWr(OFS_CTRL, 32'h0001_fc65);
    send(11'h445, 11'h445);
    drain();
    cmp1(talkActive, 1'b0);
    send(11'h463, 11'h463);
    drain();
    cmp1(talkActive, 1'b1);
    send(11'h464, 11'h464);
    drain();
    cmp1(talkActive, 1'b0);
    send(11'h445, 11'h445);
    send(11'h400, 11'h400);
    send(11'h463, 11'h463);
    drain();
    cmp1(talkActive, 1'b0);
    send(11'h445, 11'h445);
    send(11'h463, 11'h463);
    t = $urandom_range(31, 0);
    if (t == 5) t = 6;
    send({6'h22, 5'(t)}, {6'h22, 5'(t)});
    drain();
    cmp1(talkActive, 1'b0);
    send(11'h492, 11'h492);
    send(11'h425, 11'h425);
    send(11'h463, 11'h463);
    drain();
    cmp1(listenActive, 1'b1);
    cmp1(remoteCtl, 1'b1);
    send(11'h493, 11'h493);
    drain();
    cmp1(remoteCtl, 1'b0);
    send(11'h404, 11'h404, 1'b1);
    drain();
    cmp1(listenActive, 1'b1);
    for (int i = 0; i < 8; i++) begin
      send(11'h480 | 11'(i), 11'h480 | 11'(i));
      send(11'h600, 11'h600 | (11'h001 << i));
    end
    send(11'h488, 11'h488);
    send(11'h600, 11'h600);
    send(11'h481, 11'h481);
    send(11'h405, 11'h405);
    send(11'h600, 11'h600);
    send(11'h481, 11'h481);
    send(11'h415, 11'h415);
    send(11'h600, 11'h600);
    send(11'h418, 11'h418);
    drain();
    regChk(OFS_STATUS, 32'h0000_0200, 32'h0000_0200, 1'b0);
    send(11'h410, 11'h410);
    drain();
    regChk(OFS_STATUS, 32'h0000_0200, 32'h0000_0000, 1'b0);
    send(11'h408, 11'h408);
    send(11'h0ab, 11'h0ab);
    send(11'h445, 11'h445);
    send(11'h463, 11'h463);
    drain();
    b = 8'($urandom);
    regWr(OFS_TXDATA, {24'h00_0000, b});
    send(11'h560, {CLS_DATA, b});
    send({CLS_DATA, b}, 11'h540);
    send(11'h560, 11'h540);
    drain();
    b = 8'($urandom);
    regWr(OFS_TXDATA, {24'h00_0000, b});
    send(11'h560, {CLS_DATA, b});
    drain();
    regWr(OFS_TXDATA, 32'h0000_0077);
    // Not-ready first: the returning byte is answered with end-OK and 0x77 is held for the next send-data
    send(11'h542, 11'h542);
    send({CLS_DATA, b}, 11'h540);
    send(11'h560, 11'h077);
    send(11'h077, 11'h540);
    drain();
    regWr(OFS_ACCID, 32'h0000_004b);
    send(11'h563, 11'h04b);
    send(11'h04b, 11'h540);
    send(11'h562, {CLS_DATA, idB[0]});
    for (int i = 1; i < 6; i++) send({CLS_DATA, idB[i-1]}, {CLS_DATA, idB[i]});
    send({CLS_DATA, idB[5]}, 11'h540);
    drain();
    // Reset in mid-run clears the address state, so an auto address is taken this time
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    send(11'h583, 11'h584);
    drain();
    cmp1(talkActive, 1'b0);
    regChk(OFS_CTRL, 32'h0000_001f, 32'h0000_0003, 1'b0);
    wrapUp();
  end
endmodule : ldm_decoder_tb_top
